//--- period_match_timer.sv
// three 8-bit period match timers behind an apb slave
//
// Overview of operation
// - three identical timers, each with own count, period, control and flag.
// - timers run from the instruction clock, a quarter of the core clock.
// - the 8-bit count starts at zero and steps on each prescaled tick.
// - prescale select 00, 01, 10 divides by 1, 4 and 16.
// - count equal to period gives a match pulse as timer output.
// - after a match the count returns to zero and the postscaler advances.
// - count and period are read/write; reset gives count 00, period ff.
// - writing count or control clears both scaler counters.
// - every reset source clears both scaler counters.
// - the 4-bit postscaler counts matches and sets the latched flag.
// - postscale select value plus one matches per flag.
// - flag sets always; interrupt reaches cpu only when enabled.
// - the unscaled match pulse goes out to the pwm units.
// - only the first timer feeds the serial port shift clock.
// - in sleep the timer stops and count and period hold.
//
// Local design decisions: the register offsets and the APB slave port.
`include "period_match_timer_consts.svh"

module period_match_timer (
	// clock and reset (reset collects every device reset source)
	input wire logic core_clk,
	input wire logic reset,
	// processor state
	input wire logic sleep_mode,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt
	output logic irq,
	// time base outputs
	output logic [2:0] match_pulse,
	output logic spi_shift_clk
);
	// ==========================================================
	// instruction clock enable
	logic [1:0] inst_div;
	logic inst_tick;

	// one core clock stands for the oscillator, so divide by four
	assign inst_tick = (inst_div == `INST_DIV_LAST);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			inst_div <= 2'h0;
		end else begin
			inst_div <= inst_div + 2'h1;
		end
	end

	// ==========================================================
	// apb handshake
	logic access;
	logic wr_en;
	logic [31:0] next_rdata;
	logic next_err;

	assign access = psel && penable;
	// the write lands at the edge where pready is sampled high
	assign wr_en = access && pready && pwrite;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (access && !pready) begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h0000_0000 : next_rdata;
			pslverr <= next_err;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ==========================================================
	// timer instances
	period_match_timer_pkg::reg8_t count [`NUM_TIMERS];
	period_match_timer_pkg::reg8_t period [`NUM_TIMERS];
	logic [6:0] control [`NUM_TIMERS];
	logic [2:0] step;
	logic [2:0] hit;
	logic [2:0] flag_set;
	logic [2:0] scaler_clear;
	logic [2:0] wr_count;
	logic [2:0] wr_period;
	logic [2:0] wr_control;
	logic [2:0] run;

	genvar i;
	generate
		for (i = 0; i < `NUM_TIMERS; i++) begin : g_timer
			localparam logic [7:0] BASE = 8'(i) * `TIMER_STRIDE;

			assign wr_count[i] = wr_en && (paddr == BASE + `COUNT_OFF);
			assign wr_period[i] = wr_en && (paddr == BASE + `PERIOD_OFF);
			assign wr_control[i] = wr_en && (paddr == BASE + `CONTROL_OFF);
			assign scaler_clear[i] = wr_count[i] || wr_control[i];
			assign run[i] = control[i][`RUN_BIT] && !sleep_mode;
			assign hit[i] = step[i] && (count[i] == period[i]);

			prescale_divider u_prescale (
				.core_clk(core_clk),
				.reset(reset),
				.clear(scaler_clear[i]),
				.select(control[i][`PRESCALE_MSB:`PRESCALE_LSB]),
				.tick_in(inst_tick && run[i]),
				.tick_out(step[i])
			);

			postscale_counter u_postscale (
				.core_clk(core_clk),
				.reset(reset),
				.clear(scaler_clear[i]),
				.select(control[i][`POSTSCALE_MSB:`POSTSCALE_LSB]),
				.match_in(hit[i]),
				.flag_set(flag_set[i])
			);

			// a software write wins over a tick in the same cycle
			always_ff @(posedge core_clk) begin
				if (reset) begin
					count[i] <= `COUNT_RESET;
				end else if (wr_count[i]) begin
					count[i] <= pwdata[7:0];
				end else if (hit[i]) begin
					count[i] <= `COUNT_RESET;
				end else if (step[i]) begin
					count[i] <= count[i] + 8'h01;
				end
			end

			always_ff @(posedge core_clk) begin
				if (reset) begin
					period[i] <= `PERIOD_RESET;
				end else if (wr_period[i]) begin
					period[i] <= pwdata[7:0];
				end
			end

			always_ff @(posedge core_clk) begin
				if (reset) begin
					control[i] <= `CONTROL_RESET;
				end else if (wr_control[i]) begin
					control[i] <= pwdata[6:0];
				end
			end

			// unscaled match out to the pwm units
			always_ff @(posedge core_clk) begin
				if (reset) begin
					match_pulse[i] <= 1'b0;
				end else begin
					match_pulse[i] <= hit[i];
				end
			end
		end
	endgenerate

	// ==========================================================
	// serial port shift clock from the first timer only
	// each match toggles it, so the shift clock runs at half match rate
	always_ff @(posedge core_clk) begin
		if (reset) begin
			spi_shift_clk <= 1'b0;
		end else if (hit[0]) begin
			spi_shift_clk <= !spi_shift_clk;
		end
	end

	// ==========================================================
	// interrupt flags and enables
	logic [2:0] irq_status;
	logic [2:0] irq_enable;
	logic [2:0] status_clear;
	logic wr_status;
	logic wr_enable;

	assign wr_status = wr_en && (paddr == `IRQ_STATUS_OFF);
	assign wr_enable = wr_en && (paddr == `IRQ_ENABLE_OFF);
	assign status_clear = wr_status ? pwdata[2:0] : 3'h0;

	// a flag raised in the clearing cycle survives the clear
	always_ff @(posedge core_clk) begin
		if (reset) begin
			irq_status <= 3'h0;
		end else begin
			irq_status <= (irq_status & ~status_clear) | flag_set;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			irq_enable <= 3'h0;
		end else if (wr_enable) begin
			irq_enable <= pwdata[2:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_enable);
		end
	end

	// ==========================================================
	// read decode
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err = 1'b1;
		for (int t = 0; t < `NUM_TIMERS; t++) begin
			if (paddr == 8'(t) * `TIMER_STRIDE + `COUNT_OFF) begin
				next_rdata = {24'h000000, count[t]};
				next_err = 1'b0;
			end
			if (paddr == 8'(t) * `TIMER_STRIDE + `PERIOD_OFF) begin
				next_rdata = {24'h000000, period[t]};
				next_err = 1'b0;
			end
			if (paddr == 8'(t) * `TIMER_STRIDE + `CONTROL_OFF) begin
				next_rdata = {25'h0, control[t]};
				next_err = 1'b0;
			end
		end
		if (paddr == `IRQ_STATUS_OFF) begin
			next_rdata = {29'h0, irq_status};
			next_err = 1'b0;
		end
		if (paddr == `IRQ_ENABLE_OFF) begin
			next_rdata = {29'h0, irq_enable};
			next_err = 1'b0;
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	a_inst_rate: assert property (
		inst_tick |=> !inst_tick [*3] ##1 inst_tick)
		else $error("instruction tick not every fourth cycle");

	a_count_step: assert property (
		step[0] && !hit[0] && !wr_count[0] |=>
			count[0] == $past(count[0]) + 8'h01)
		else $error("count did not step by one");

	a_count_wrap: assert property (
		hit[1] && !wr_count[1] |=> count[1] == 8'h00 ##1 match_pulse[1] == 1'b0)
		else $error("count not cleared after match");

	a_match_out: assert property (
		match_pulse[2] |-> $past(step[2] && count[2] == period[2]))
		else $error("match pulse without equality");

	a_sleep_hold: assert property (
		sleep_mode && !wr_count[0] && !wr_period[0] |=>
			$stable(count[0]) && $stable(period[0]))
		else $error("timer changed during sleep");

	a_stop_hold: assert property (
		!control[0][`RUN_BIT] && !wr_count[0] |=> $stable(count[0]))
		else $error("stopped timer counted");

	a_reset_vals: assert property (
		$past(reset) |-> count[2] == 8'h00 && period[2] == 8'hff)
		else $error("wrong values after reset");

	a_flag_latch: assert property (
		flag_set[0] |=> irq_status[0] ##1 (irq || !$past(irq_enable[0])))
		else $error("flag not latched on postscale");

	a_irq_gate: assert property (
		irq == $past(|(irq_status & irq_enable)))
		else $error("interrupt not gated by enable");

	a_prescale_gap: assert property (
		step[0] && control[0][1:0] == 2'h1 && !scaler_clear[0] |=>
			!step[0] [*8])
		else $error("divide by four stepped early");

	a_spi_source: assert property (
		spi_shift_clk != $past(spi_shift_clk) |-> $past(hit[0]))
		else $error("shift clock moved without first timer match");

	// a cleared divider needs at least four ticks, so no step for eight cycles
	a_write_clear: assert property (
		wr_control[0] && pwdata[1:0] != 2'h0 |=> !step[0] [*8])
		else $error("control write left scaler running");

	a_pready_pulse: assert property (
		pready |=> !pready)
		else $error("pready held longer than one cycle");

	a_read_upper: assert property (
		pready |-> prdata[31:8] == 24'h000000)
		else $error("upper read data bits not zero");

	a_period_hold: assert property (
		!wr_period[0] |=> $stable(period[0]))
		else $error("period changed without a write");

	a_count_write: assert property (
		wr_count[1] |=> count[1] == $past(pwdata[7:0]))
		else $error("count write did not land");

	a_flag_sticky: assert property (
		irq_status[0] && !status_clear[0] |=> irq_status[0])
		else $error("flag dropped without a clear");

	a_flag_clear: assert property (
		status_clear[0] && !flag_set[0] |=> !irq_status[0])
		else $error("flag survived a write-one clear");

	a_irq_low: assert property (
		irq_enable == 3'h0 |=> !irq)
		else $error("interrupt raised while all disabled");

	a_spi_toggle: assert property (
		hit[0] |=> spi_shift_clk != $past(spi_shift_clk))
		else $error("shift clock missed a first timer match");

	a_pulse_once: assert property (
		match_pulse[0] |=> !match_pulse[0])
		else $error("match pulse longer than one cycle");

	a_ctl_top: assert property (
		pready && !pwrite && paddr == 8'h02 * `TIMER_STRIDE + `CONTROL_OFF
			|-> !prdata[7])
		else $error("control top bit read as one");
endmodule // period_match_timer

//--- period_match_timer_bench.sv
// self-checking testbench for the period match timer
`include "period_match_timer_consts.svh"

module period_match_timer_bench;
	timeunit 1ns;
	timeprecision 1ns;

	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic sleep_mode = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [2:0] match_pulse;
	logic spi_shift_clk;
	int err_count = 0;
	int comparisons = 0;
	int cyc = 0;
	int last_at = 0;
	int gap = 0;
	int mcount = 0;
	int irq_at = 0;
	int m1 = 0;
	int m2 = 0;
	logic irq_q = 1'b0;
	logic [31:0] rd;
	logic [31:0] held;
	logic er;
	int base;
	int posts[3] = '{0, 5, 15};

	always #25 core_clk = ~core_clk;

	period_match_timer u_dut (
		.core_clk(core_clk),
		.reset(reset),
		.sleep_mode(sleep_mode),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.irq(irq),
		.match_pulse(match_pulse),
		.spi_shift_clk(spi_shift_clk)
	);

	// ==========================================================
	// match monitor: spacing of timer 0 matches, matches at irq rise
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		irq_q <= irq;
		if (match_pulse[0] === 1'b1) begin
			mcount <= mcount + 1;
			gap <= cyc - last_at;
			last_at <= cyc;
		end
		if (irq === 1'b1 && irq_q !== 1'b1) irq_at <= mcount;
		if (match_pulse[1] === 1'b1) m1 <= m1 + 1;
		if (match_pulse[2] === 1'b1) m2 <= m2 + 1;
	end

	// ==========================================================
	// helpers
	task automatic end_of_test;
		$display("counts: %0d mismatches, %0d comparisons", err_count,
			comparisons);
		if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [7:0] ra(input int t, input logic [7:0] off);
		ra = off + 8'(t) * `TIMER_STRIDE;
	endfunction

	function automatic logic [31:0] ctl(input logic run, input int post,
		input int pre);
		ctl = {25'h0, 4'(post), run, 2'(pre)};
	endfunction

	// one apb transfer; entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			err_count++;
			$display("MISMATCH pready expected 1 seen %b", pready);
			end_of_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rchk(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask

	// bounded waits; a run-out counts as a mismatch
	task automatic wait_matches(input int target);
		int n;
		n = 0;
		while (mcount < target && n < 4000) begin
			@(posedge core_clk);
			n++;
		end
		if (mcount < target) begin
			chk("match wait", 32'h1, 32'h0);
			end_of_test();
		end
	endtask

	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 1000) begin
			@(posedge core_clk);
			n++;
		end
		@(posedge core_clk);
		if (irq !== 1'b1) begin
			chk("irq wait", 32'h1, 32'h0);
			end_of_test();
		end
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		for (int t = 0; t < 3; t++) begin
			rchk("count reset", ra(t, `COUNT_OFF), 32'h0);
			rchk("period reset", ra(t, `PERIOD_OFF), 32'hff);
			rchk("control reset", ra(t, `CONTROL_OFF), 32'h0);
		end
		wr(ra(1, `COUNT_OFF), 32'h5a);
		rchk("count rw", ra(1, `COUNT_OFF), 32'h5a);
		chk("mapped error", 32'h0, {31'h0, er});
		wr(ra(1, `PERIOD_OFF), 32'h3c);
		rchk("period rw", ra(1, `PERIOD_OFF), 32'h3c);
		wr(ra(2, `CONTROL_OFF), 32'hff);
		rchk("control top bit", ra(2, `CONTROL_OFF), 32'h7f);
		apb(1'b0, 8'h3c, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		// period 1 gives a match every second prescaled tick
		wr(ra(0, `PERIOD_OFF), 32'h1);
		for (int c = 0; c < 4; c++) begin
			wr(ra(0, `CONTROL_OFF), ctl(1'b1, 0, c));
			base = mcount;
			wait_matches(base + 3);
			chk("match spacing", 32'(8 << (2 * c)), gap);
		end
		wr(ra(0, `PERIOD_OFF), 32'h2);
		wr(`IRQ_ENABLE_OFF, 32'h1);
		foreach (posts[i]) begin
			wr(ra(0, `CONTROL_OFF), ctl(1'b0, 0, 0));
			wr(`IRQ_STATUS_OFF, 32'h1);
			// irq is registered: let the edge after the clear pass
			@(posedge core_clk);
			chk("irq after clear", 32'h0, {31'h0, irq});
			base = mcount;
			wr(ra(0, `CONTROL_OFF), ctl(1'b1, posts[i], 0));
			wait_irq();
			chk("matches per flag", 32'(posts[i] + 1), irq_at - base);
		end
		wr(`IRQ_ENABLE_OFF, 32'h0);
		@(posedge core_clk);
		chk("irq masked", 32'h0, {31'h0, irq});
		rchk("flag while masked", `IRQ_STATUS_OFF, 32'h1);
		wr(`IRQ_ENABLE_OFF, 32'h1);
		@(posedge core_clk);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		wr(ra(0, `CONTROL_OFF), ctl(1'b0, 0, 0));
		wr(`IRQ_STATUS_OFF, 32'h1);
		rchk("flag cleared", `IRQ_STATUS_OFF, 32'h0);
		chk("irq cleared", 32'h0, {31'h0, irq});
		// sleep freezes a running count
		wr(ra(0, `PERIOD_OFF), 32'hff);
		wr(ra(0, `CONTROL_OFF), ctl(1'b1, 0, 0));
		sleep_mode <= 1'b1;
		repeat (4) @(posedge core_clk);
		apb(1'b0, ra(0, `COUNT_OFF), 32'h0);
		held = rd;
		repeat (40) @(posedge core_clk);
		rchk("count in sleep", ra(0, `COUNT_OFF), held);
		rchk("period in sleep", ra(0, `PERIOD_OFF), 32'hff);
		sleep_mode <= 1'b0;
		repeat (40) @(posedge core_clk);
		apb(1'b0, ra(0, `COUNT_OFF), 32'h0);
		comparisons++;
		if (rd === held) begin
			err_count++;
			$display("MISMATCH count after wake expected change seen %h", rd);
		end
		wr(ra(0, `CONTROL_OFF), ctl(1'b0, 0, 0));
		repeat (4) @(posedge core_clk);
		chk("shift clock", {31'h0, mcount[0]}, {31'h0, spi_shift_clk});
		// timers 1 and 2 run on their own; their flags stay masked
		for (int t = 1; t < 3; t++) begin
			wr(ra(t, `PERIOD_OFF), 32'h1);
			wr(ra(t, `COUNT_OFF), 32'h0);
			wr(ra(t, `CONTROL_OFF), ctl(1'b1, 0, 0));
		end
		repeat (40) @(posedge core_clk);
		rchk("other flags", `IRQ_STATUS_OFF, 32'h6);
		chk("other irq masked", 32'h0, {31'h0, irq});
		chk("timer 1 pulses", 32'h1, {31'h0, m1 > 0});
		chk("timer 2 pulses", 32'h1, {31'h0, m2 > 0});
		end_of_test();
	end
endmodule // period_match_timer_bench

//--- period_match_timer_consts.svh
// register map, field positions, reset values and timing counts
`ifndef PERIOD_MATCH_TIMER_CONSTS_SVH
`define PERIOD_MATCH_TIMER_CONSTS_SVH

// ==========================================================
// instances and clocking
`define NUM_TIMERS 3
`define INST_DIV_LAST 2'h3

// ==========================================================
// register offsets (byte addresses on apb)
`define TIMER_STRIDE 8'h10
`define COUNT_OFF 8'h00
`define PERIOD_OFF 8'h04
`define CONTROL_OFF 8'h08
`define IRQ_STATUS_OFF 8'h30
`define IRQ_ENABLE_OFF 8'h34

// ==========================================================
// control field positions
`define PRESCALE_LSB 0
`define PRESCALE_MSB 1
`define RUN_BIT 2
`define POSTSCALE_LSB 3
`define POSTSCALE_MSB 6

// ==========================================================
// reset values
`define COUNT_RESET 8'h00
`define PERIOD_RESET 8'hff
`define CONTROL_RESET 7'h00

// ==========================================================
// prescaler terminal counts (ratio minus one)
`define PRESCALE_LAST_1 6'h00
`define PRESCALE_LAST_4 6'h03
`define PRESCALE_LAST_16 6'h0f
`define PRESCALE_LAST_64 6'h3f

`endif

//--- period_match_timer_pkg.sv
// shared types of the period match timer
package period_match_timer_pkg;
	typedef logic [7:0] reg8_t;
	typedef logic [1:0] prescale_sel_t;
	typedef logic [3:0] postscale_sel_t;
	typedef logic [5:0] prescale_cnt_t;
endpackage

//--- postscale_counter.sv
// postscale counter between the match pulse and the interrupt flag
module postscale_counter (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// control
	input wire logic clear,
	input wire period_match_timer_pkg::postscale_sel_t select,
	// events
	input wire logic match_in,
	output logic flag_set
);
	period_match_timer_pkg::postscale_sel_t cnt;

	// a shrinking select makes the next match fire at once, not wrap
	assign flag_set = match_in && (cnt >= select);

	always_ff @(posedge core_clk) begin
		if (reset || clear) begin
			cnt <= 4'h0;
		end else if (flag_set) begin
			cnt <= 4'h0;
		end else if (match_in) begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule // postscale_counter

//--- prescale_divider.sv
// prescale counter in front of the timer count
`include "period_match_timer_consts.svh"

module prescale_divider (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// control
	input wire logic clear,
	input wire period_match_timer_pkg::prescale_sel_t select,
	// ticks
	input wire logic tick_in,
	output logic tick_out
);
	period_match_timer_pkg::prescale_cnt_t cnt;
	period_match_timer_pkg::prescale_cnt_t last;

	always_comb begin
		case (select)
			2'h0: last = `PRESCALE_LAST_1;
			2'h1: last = `PRESCALE_LAST_4;
			2'h2: last = `PRESCALE_LAST_16;
			2'h3: last = `PRESCALE_LAST_64;
			default: last = `PRESCALE_LAST_1;
		endcase
	end

	assign tick_out = tick_in && (cnt >= last);

	always_ff @(posedge core_clk) begin
		if (reset || clear) begin
			cnt <= 6'h00;
		end else if (tick_out) begin
			cnt <= 6'h00;
		end else if (tick_in) begin
			cnt <= cnt + 6'h01;
		end
	end
endmodule // prescale_divider
